//--- inc/flow_ctrl_pkg.sv
// flow_ctrl_pkg: constants, register map and op kinds for the program flow core
// assumes a single 10 MHz system clock and a decoded instruction supplied by program memory
package flow_ctrl_pkg;

  // ==========================================================
  // widths and sizes
  localparam int PC_W = 13;
  localparam int PC_HI_W = 5;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam int WB_ADR_W = 4;

  // ==========================================================
  // vectors and reset values
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [3:0] SP_RESET = 4'h0;
  localparam logic [3:0] SP_FULL = 4'h8;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // ==========================================================
  // register map, byte addresses
  localparam logic [3:0] PC_LOW_BYTE_OFS = 4'h0;
  localparam logic [3:0] CORE_STATE_OFS = 4'h4;
  // core state field positions
  localparam int CS_ACC_LSB = 0;
  localparam int CS_CARRY_BIT = 8;
  localparam int CS_ZERO_BIT = 9;
  localparam int CS_IRQ_BIT = 10;

  // ==========================================================
  // cycle phases, one instruction cycle
  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b10,
    PH_T4 = 2'b11
  } phase_e;

  // decoded operation kinds
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_JUMP = 4'b0001,
    OP_CALL = 4'b0010,
    OP_SUB_RETURN = 4'b0011,
    OP_INT_RETURN = 4'b0100,
    OP_SKIP_ZERO = 4'b0101,
    OP_ADD = 4'b0110,
    OP_SUB = 4'b0111,
    OP_AND = 4'b1000,
    OP_OR = 4'b1001,
    OP_XOR = 4'b1010,
    OP_ROT_RIGHT = 4'b1011,
    OP_ROT_LEFT = 4'b1100,
    OP_INC = 4'b1101,
    OP_DEC = 4'b1110,
    OP_LOAD = 4'b1111
  } op_kind_e;

endpackage : flow_ctrl_pkg

//--- rtl/mcu_program_flow_control.sv
// mcu_program_flow_control: phase generator, fetch/execute pipeline, program counter,
// return stack and accumulator alu of a small 8-bit controller
// assumes program memory answers with decoded fields for pm_addr within one clock,
// interrupt requests arrive from logic on sys_clk, registers over classic wishbone
//
// Function
// - four non-overlapping phases form one instruction cycle
// - counter advances and fetch happens at phase one
// - fetch overlaps execute; extended ops take two
// - branches cost one extra cycle
// - non-branching instruction advances counter by one
// - 13-bit counter, only low byte software visible
// - jump, call, interrupt, reset load target directly
// - taken skip discards prefetch, runs idle cycle
// - low byte write jumps within page, idle cycle
// - eight-level hidden stack holds counter values only
// - hidden stack pointer resets to zero, stack empty
// - call or interrupt acknowledge pushes counter
// - returns pop stack into counter
// - full stack defers interrupt acknowledge until return
// - call on full stack overflows, loses oldest
// - eight-bit alu works through accumulator
// - alu writes result; only add, sub update both carry and zero
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ns
module mcu_program_flow_control import flow_ctrl_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // program memory
  output logic [PC_W-1:0] pm_addr,
  input wire logic [3:0] pm_op_kind,
  input wire logic pm_op_ext,
  input wire logic [PC_W-1:0] pm_op_target,
  input wire logic [DATA_W-1:0] pm_op_imm,
  // interrupt logic
  input wire logic irq_req,
  output logic int_ack,
  // phase and core state
  output logic [3:0] cycle_phase_clocks,
  output logic [DATA_W-1:0] acc_out
);

  // ==========================================================
  // state
  phase_e phase_r;
  logic [PC_W-1:0] pc_r;
  logic fetch_valid_r, exec_valid_r, ext_wait_r;
  op_kind_e fetch_kind_r, exec_kind_r;
  logic fetch_ext_r, exec_ext_r;
  logic [PC_W-1:0] fetch_target_r, exec_target_r;
  logic [DATA_W-1:0] fetch_imm_r, exec_imm_r;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [DATA_W-1:0] acc_r;
  logic carry_r, zero_r, irq_pending_r;
  logic low_wr_pend_r;
  logic [DATA_W-1:0] low_wr_val_r;
  logic ack_r;
  logic [31:0] rdat_r;

  logic at_t1, at_t4, exec_go, stack_full, stack_empty;
  logic is_call, is_jump, is_ret, skip_taken, exec_branch, low_wr_apply, int_take, redirect;
  logic bus_wr, bus_rd, wr_low;
  logic [PC_W-1:0] ret_addr, stack_top;
  logic [8:0] alu_sum;

  // ==========================================================
  // phase generation
  assign at_t1 = (phase_r == PH_T1);
  assign at_t4 = (phase_r == PH_T4);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= PH_T1;
    end else begin
      unique case (phase_r)
        PH_T1: phase_r <= PH_T2;
        PH_T2: phase_r <= PH_T3;
        PH_T3: phase_r <= PH_T4;
        PH_T4: phase_r <= PH_T1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cycle_phase_clocks <= 4'h1;
    end else begin
      cycle_phase_clocks <= {cycle_phase_clocks[2:0], cycle_phase_clocks[3]};
    end
  end

  // ==========================================================
  // decode of the executing instruction
  assign stack_full = (sp_r == SP_FULL);
  assign stack_empty = (sp_r == SP_RESET);
  assign stack_top = stack_empty ? RESET_VECTOR : stack_r[3'(sp_r - 4'h1)];
  assign exec_go = at_t4 && exec_valid_r && !(exec_ext_r && !ext_wait_r);
  assign is_jump = exec_go && (exec_kind_r == OP_JUMP);
  assign is_call = exec_go && (exec_kind_r == OP_CALL);
  assign is_ret = exec_go && (exec_kind_r == OP_SUB_RETURN || exec_kind_r == OP_INT_RETURN);
  assign skip_taken = exec_go && (exec_kind_r == OP_SKIP_ZERO) && (acc_r == ACC_RESET);
  assign exec_branch = is_jump || is_call || is_ret;
  assign low_wr_apply = at_t4 && low_wr_pend_r && !exec_branch;
  // interrupt waits for a free level and for a quiet pipeline slot
  assign int_take = at_t4 && irq_pending_r && !stack_full && !exec_branch && !low_wr_apply &&
                    !skip_taken && !(exec_valid_r && exec_ext_r && !ext_wait_r);
  assign redirect = exec_branch || low_wr_apply || int_take || skip_taken;
  // counter already points past the prefetched word
  assign ret_addr = pc_r - 13'h0001;
  assign int_ack = int_take;
  assign pm_addr = pc_r;
  assign acc_out = acc_r;

  // ==========================================================
  // program counter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= RESET_VECTOR;
    end else if (at_t1 && !ext_wait_r) begin
      pc_r <= pc_r + 13'h0001;
    end else if (is_jump || is_call) begin
      pc_r <= exec_target_r;
    end else if (is_ret) begin
      pc_r <= stack_top;
    end else if (low_wr_apply) begin
      pc_r <= {pc_r[PC_W-1:DATA_W], low_wr_val_r};
    end else if (int_take) begin
      pc_r <= INT_VECTOR;
    end
  end

  // ==========================================================
  // fetch and execute stages
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_valid_r <= 1'b0;
      exec_valid_r <= 1'b0;
      fetch_kind_r <= OP_NOP;
      exec_kind_r <= OP_NOP;
      fetch_ext_r <= 1'b0;
      exec_ext_r <= 1'b0;
      fetch_target_r <= RESET_VECTOR;
      exec_target_r <= RESET_VECTOR;
      fetch_imm_r <= ACC_RESET;
      exec_imm_r <= ACC_RESET;
    end else if (at_t1 && !ext_wait_r) begin
      exec_valid_r <= fetch_valid_r;
      exec_kind_r <= fetch_kind_r;
      exec_ext_r <= fetch_ext_r;
      exec_target_r <= fetch_target_r;
      exec_imm_r <= fetch_imm_r;
      fetch_valid_r <= 1'b1;
      fetch_kind_r <= op_kind_e'(pm_op_kind);
      fetch_ext_r <= pm_op_ext;
      fetch_target_r <= pm_op_target;
      fetch_imm_r <= pm_op_imm;
    end else if (redirect) begin
      fetch_valid_r <= 1'b0;
    end
  end

  // extended instructions hold the pipeline for one more cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_wait_r <= 1'b0;
    end else if (at_t4 && exec_valid_r && exec_ext_r) begin
      ext_wait_r <= !ext_wait_r;
    end
  end

  // ==========================================================
  // return stack
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_r <= SP_RESET;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= RESET_VECTOR;
      end
    end else if (is_call || int_take) begin
      if (stack_full) begin
        for (int i = 0; i < STACK_DEPTH - 1; i++) begin
          stack_r[i] <= stack_r[i+1];
        end
        stack_r[STACK_DEPTH-1] <= ret_addr;
      end else begin
        stack_r[3'(sp_r)] <= ret_addr;
        sp_r <= sp_r + 4'h1;
      end
    end else if (is_ret && !stack_empty) begin
      sp_r <= sp_r - 4'h1;
    end
  end

  // interrupt request flag, a new request wins over the acknowledge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pending_r <= 1'b0;
    end else if (irq_req) begin
      irq_pending_r <= 1'b1;
    end else if (int_take) begin
      irq_pending_r <= 1'b0;
    end
  end

  // ==========================================================
  // accumulator alu
  always_comb begin
    alu_sum = 9'h000;
    if (exec_kind_r == OP_SUB) begin
      alu_sum = {1'b0, acc_r} + {1'b0, ~exec_imm_r} + 9'h001;
    end else begin
      alu_sum = {1'b0, acc_r} + {1'b0, exec_imm_r};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= ACC_RESET;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
    end else if (exec_go) begin
      unique case (exec_kind_r)
        OP_ADD, OP_SUB: begin
          acc_r <= alu_sum[7:0];
          carry_r <= alu_sum[8];
          zero_r <= (alu_sum[7:0] == ACC_RESET);
        end
        OP_AND: begin
          acc_r <= acc_r & exec_imm_r;
          zero_r <= ((acc_r & exec_imm_r) == ACC_RESET);
        end
        OP_OR: begin
          acc_r <= acc_r | exec_imm_r;
          zero_r <= ((acc_r | exec_imm_r) == ACC_RESET);
        end
        OP_XOR: begin
          acc_r <= acc_r ^ exec_imm_r;
          zero_r <= ((acc_r ^ exec_imm_r) == ACC_RESET);
        end
        OP_ROT_RIGHT: begin
          acc_r <= {carry_r, acc_r[7:1]};
          carry_r <= acc_r[0];
        end
        OP_ROT_LEFT: begin
          acc_r <= {acc_r[6:0], carry_r};
          carry_r <= acc_r[7];
        end
        OP_INC: begin
          acc_r <= acc_r + 8'h01;
          zero_r <= (acc_r == 8'hff);
        end
        OP_DEC: begin
          acc_r <= acc_r - 8'h01;
          zero_r <= (acc_r == 8'h01);
        end
        OP_LOAD: begin
          acc_r <= exec_imm_r;
        end
        OP_NOP, OP_JUMP, OP_CALL, OP_SUB_RETURN, OP_INT_RETURN, OP_SKIP_ZERO: begin
          acc_r <= acc_r;
        end
      endcase
    end
  end

  // ==========================================================
  // wishbone slave, one wait state, writes land with ack, unmapped reads zero
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign bus_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
  assign wr_low = bus_wr && (wb_adr_i == PC_LOW_BYTE_OFS) && wb_sel_i[0];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      rdat_r <= 32'h0000_0000;
      if (bus_rd && wb_adr_i == PC_LOW_BYTE_OFS) begin
        rdat_r <= {24'h00_0000, pc_r[DATA_W-1:0]};
      end else if (bus_rd && wb_adr_i == CORE_STATE_OFS) begin
        rdat_r[CS_ACC_LSB +: DATA_W] <= acc_r;
        rdat_r[CS_CARRY_BIT] <= carry_r;
        rdat_r[CS_ZERO_BIT] <= zero_r;
        rdat_r[CS_IRQ_BIT] <= irq_pending_r;
      end
    end
  end

  // low byte write waits for a phase four with no branch executing, a new write wins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_wr_pend_r <= 1'b0;
      low_wr_val_r <= ACC_RESET;
    end else if (wr_low) begin
      low_wr_pend_r <= 1'b1;
      low_wr_val_r <= wb_dat_i[DATA_W-1:0];
    end else if (low_wr_apply) begin
      low_wr_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_PHASE_ROTATE: assert property (at_t1 |=> phase_r == PH_T2 ##1 phase_r == PH_T3 ##1 at_t4 ##1 at_t1)
    else $error("phase sequence broken");
  AST_FETCH_ADVANCE: assert property ((at_t1 && !ext_wait_r) |=> pc_r == $past(pc_r) + 13'h0001)
    else $error("counter did not advance at phase one");
  AST_EXT_TWO_CYCLES: assert property ((at_t4 && exec_valid_r && exec_ext_r && !ext_wait_r) |-> !exec_go ##4 exec_go)
    else $error("extended op did not take two cycles");
  AST_JUMP_LOAD: assert property (is_jump |=> pc_r == $past(exec_target_r) && !fetch_valid_r ##1 (phase_r == PH_T2 && !exec_valid_r))
    else $error("jump target or idle slot wrong");
  AST_PLAIN_HOLD: assert property ((at_t4 && !redirect) |=> pc_r == $past(pc_r))
    else $error("counter moved on a plain instruction");
  AST_SKIP_DUMMY: assert property (skip_taken |=> !fetch_valid_r ##1 !exec_valid_r)
    else $error("skip did not insert an idle cycle");
  AST_PAGE_KEEP: assert property (low_wr_apply |=> pc_r[PC_W-1:DATA_W] == $past(pc_r[PC_W-1:DATA_W]) && !fetch_valid_r)
    else $error("low byte write left the page");
  AST_SP_RANGE: assert property (sp_r <= SP_FULL)
    else $error("stack pointer out of range");
  AST_CALL_PUSH: assert property ((is_call && !stack_full) |=> sp_r == $past(sp_r) + 4'h1)
    else $error("call did not push");
  AST_RET_POP: assert property ((is_ret && !stack_empty) |=> pc_r == $past(stack_top) && sp_r == $past(sp_r) - 4'h1)
    else $error("return did not restore counter");
  AST_FULL_DEFER: assert property ((stack_full && irq_pending_r) |-> !int_ack)
    else $error("interrupt acknowledged on full stack");
  AST_OVERFLOW: assert property ((is_call && stack_full) |=> stack_full && stack_r[STACK_DEPTH-2] == $past(stack_r[STACK_DEPTH-1]))
    else $error("overflow did not drop oldest entry");
  AST_ADD_RESULT: assert property ((exec_go && exec_kind_r == OP_ADD) |=> {carry_r, acc_r} == $past(alu_sum))
    else $error("add result or carry wrong");
  AST_EMPTY_RET: assert property ((is_ret && stack_empty) |=> pc_r == RESET_VECTOR && stack_empty)
    else $error("empty return not deterministic");

endmodule : mcu_program_flow_control

//--- test/prog_mem_model.sv
// prog_mem_model: program memory and interrupt request source facing the flow core
// assumes the bench loads words with put and asks for requests with raise_irq
`timescale 1ns/1ns
module prog_mem_model import flow_ctrl_pkg::*; (
  // clock
  input wire logic sys_clk,
  // program memory
  input wire logic [PC_W-1:0] pm_addr,
  output logic [3:0] pm_op_kind,
  output logic pm_op_ext,
  output logic [PC_W-1:0] pm_op_target,
  output logic [DATA_W-1:0] pm_op_imm,
  // interrupt
  output logic irq_req
);
  // ==========
  // storage, answers within the same clock
  logic [25:0] mem_r [512];
  initial irq_req = 1'b0;
  assign {pm_op_kind, pm_op_ext, pm_op_target, pm_op_imm} = mem_r[pm_addr[8:0]];

  task automatic clear();
    for (int i = 0; i < 512; i++) mem_r[i] = '0;
  endtask : clear

  task automatic put(input int a, input op_kind_e k, input int t, input int d, input logic e);
    mem_r[a[8:0]] = {k, e, t[12:0], d[7:0]};
  endtask : put

  // one clock wide request, launched after an edge
  task automatic raise_irq();
    irq_req <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 1'b0;
  endtask : raise_irq
endmodule : prog_mem_model

//--- test/mcu_program_flow_control_test.sv
// mcu_program_flow_control_test: self-checking bench for the program flow core
// assumes prog_mem_model beside the core and a 10 MHz clock
`timescale 1ns/1ns
module mcu_program_flow_control_test import flow_ctrl_pkg::*; ();
  // ==========
  // signals
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, irq, int_ack, ext, rst_q;
  logic [PC_W-1:0] pm_addr, tgt;
  logic [3:0] kind, phase, ph_q;
  logic [DATA_W-1:0] imm, acc;
  int num_errors = 0;
  int samples_checked = 0;
  int cnt [512];
  int nf, at14, acks;

  always #50 sys_clk = ~sys_clk;

  mcu_program_flow_control dut (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pm_addr(pm_addr), .pm_op_kind(kind), .pm_op_ext(ext), .pm_op_target(tgt), .pm_op_imm(imm),
    .irq_req(irq), .int_ack(int_ack), .cycle_phase_clocks(phase), .acc_out(acc)
  );
  prog_mem_model pm (
    .sys_clk(sys_clk), .pm_addr(pm_addr), .pm_op_kind(kind), .pm_op_ext(ext),
    .pm_op_target(tgt), .pm_op_imm(imm), .irq_req(irq)
  );

  // ==========
  // checking and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked += 1;
    if (got !== exp) begin
      num_errors += 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n += 1;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    wb(1'b0, a, 4'hF, '0, q);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask : wr

  task automatic do_reset(input int n);
    rst_b <= 1'b0;
    repeat (n) @(posedge sys_clk);
    for (int i = 0; i < 512; i++) cnt[i] = 0;
    nf = 0;
    at14 = -1;
    acks = 0;
    chk(pm_addr, RESET_VECTOR);
    chk(phase, 4'h1);
    chk(acc, ACC_RESET);
    rst_b <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset

  task automatic wait_addr(input logic [12:0] a, input int n);
    int i;
    i = 0;
    while (pm_addr !== a && i < n) begin
      @(posedge sys_clk);
      i += 1;
    end
    chk(pm_addr, a);
  endtask : wait_addr

  // fetch log sampled once per instruction cycle, acknowledges counted and phase rotation checked every clock
  always @(posedge sys_clk) begin
    if (rst_b && phase[0]) begin
      cnt[pm_addr[8:0]] += 1;
      if (pm_addr === 13'h0014 && at14 < 0) at14 = nf;
      nf += 1;
    end
    if (rst_b && int_ack === 1'b1) acks += 1;
    if (rst_b && rst_q) chk(phase, {ph_q[2:0], ph_q[3]});
    ph_q = phase;
    rst_q = rst_b;
  end

  // ==========
  // scenarios
  task automatic t_alu();
    op_kind_e ops [9] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC, OP_ROT_RIGHT, OP_ROT_LEFT};
    int av [9] = '{8'h05, 8'h05, 8'hF0, 8'hF0, 8'hFF, 8'hFF, 8'h01, 8'h02, 8'h40};
    int bv [9] = '{8'hFF, 8'h05, 8'h0F, 8'h0F, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
    int ev [9] = '{12'h104, 12'h300, 12'h200, 12'h0FF, 12'h0F0, 12'h200, 12'h200, 12'h001, 12'h080};
    int mv [9] = '{12'h3FF, 12'h3FF, 12'h2FF, 12'h2FF, 12'h2FF, 12'h2FF, 12'h2FF, 12'h07F, 12'h0FE};
    logic [31:0] q;
    for (int i = 0; i < 9; i++) begin
      pm.clear();
      pm.put(0, OP_LOAD, 0, av[i], 1'b0);
      pm.put(1, ops[i], 0, bv[i], 1'b0);
      pm.put(2, OP_JUMP, 2, 0, 1'b0);
      do_reset(2);
      repeat (40) @(posedge sys_clk);
      rd(CORE_STATE_OFS, q);
      chk(q & mv[i], ev[i]);
    end
  endtask : t_alu

  task automatic t_flow();
    int ad [7] = '{12'h003, 12'h010, 12'h011, 12'h013, 12'h020, 12'h021, 12'h022};
    int ex [7] = '{1, 1, 2, 1, 1, 1, 0};
    pm.clear();
    pm.put(0, OP_LOAD, 0, 8'h05, 1'b1);
    pm.put(1, OP_ADD, 0, 8'hFF, 1'b0);
    pm.put(2, OP_JUMP, 12'h010, 0, 1'b0);
    pm.put(12'h010, OP_CALL, 12'h020, 0, 1'b0);
    pm.put(12'h011, OP_LOAD, 0, 8'h00, 1'b0);
    pm.put(12'h012, OP_SKIP_ZERO, 0, 0, 1'b0);
    pm.put(12'h013, OP_LOAD, 0, 8'hAA, 1'b0);
    pm.put(12'h014, OP_JUMP, 12'h014, 0, 1'b0);
    pm.put(12'h020, OP_SUB_RETURN, 0, 0, 1'b0);
    do_reset(2);
    repeat (80) @(posedge sys_clk);
    chk(at14, 12);
    for (int i = 0; i < 7; i++) chk(cnt[ad[i]], ex[i]);
    chk(acc, 8'h00);
  endtask : t_flow

  task automatic t_irq();
    logic [31:0] q;
    int n;
    pm.clear();
    pm.put(0, OP_JUMP, 12'h030, 0, 1'b0);
    for (int i = 0; i < 8; i++) pm.put(12'h030 + i, OP_CALL, 12'h031 + i, 0, 1'b0);
    pm.put(12'h040, OP_SUB_RETURN, 0, 0, 1'b0);
    pm.put(4, OP_INT_RETURN, 0, 0, 1'b0);
    do_reset(2);
    wait_addr(13'h0039, 200);
    pm.raise_irq();
    repeat (8) @(posedge sys_clk);
    rd(CORE_STATE_OFS, q);
    chk(q[CS_IRQ_BIT], 1'b1);
    chk(acks, 0);
    n = 0;
    while (int_ack !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n += 1;
    end
    chk(cnt[12'h041] != 0, 1'b1);
    #1;
    chk(pm_addr, INT_VECTOR);
    @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    rd(CORE_STATE_OFS, q);
    chk(q[CS_IRQ_BIT], 1'b0);
    chk(acks, 1);
  endtask : t_irq

  task automatic t_ovf();
    pm.clear();
    pm.put(0, OP_JUMP, 12'h050, 0, 1'b0);
    pm.put(12'h050, OP_CALL, 12'h060, 0, 1'b0);
    pm.put(12'h051, OP_JUMP, 12'h051, 0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      pm.put(12'h060 + 2 * k, OP_CALL, 12'h062 + 2 * k, 0, 1'b0);
      pm.put(12'h061 + 2 * k, OP_SUB_RETURN, 0, 0, 1'b0);
    end
    pm.put(12'h070, OP_SUB_RETURN, 0, 0, 1'b0);
    do_reset(2);
    repeat (400) @(posedge sys_clk);
    chk(cnt[0] > 1, 1'b1);
    chk(cnt[12'h052], 0);
  endtask : t_ovf

  task automatic t_pcl();
    logic [31:0] q;
    pm.clear();
    pm.put(0, OP_JUMP, 12'h105, 0, 1'b0);
    pm.put(12'h105, OP_JUMP, 12'h105, 0, 1'b0);
    pm.put(12'h142, OP_JUMP, 12'h142, 0, 1'b0);
    do_reset(2);
    repeat (40) @(posedge sys_clk);
    wr(PC_LOW_BYTE_OFS, 4'h0, 32'h0000_0077);
    rd(PC_LOW_BYTE_OFS, q);
    chk(q[7:0] == 8'h05 || q[7:0] == 8'h06, 1'b1);
    rd(4'h8, q);
    chk(q, 32'h0000_0000);
    wr(CORE_STATE_OFS, 4'h1, 32'h0000_00FF);
    rd(CORE_STATE_OFS, q);
    chk(q[7:0], 8'h00);
    wr(PC_LOW_BYTE_OFS, 4'h1, 32'h0000_0042);
    wait_addr(13'h0142, 40);
    rd(PC_LOW_BYTE_OFS, q);
    chk(q[7:1], 7'h21);
  endtask : t_pcl

  // ==========
  // sequence and watchdog
  initial begin
    pm.clear();
    do_reset(20);
    t_alu();
    t_flow();
    t_irq();
    t_ovf();
    t_pcl();
    end_of_test();
  end

  initial begin
    #1_000_000;
    num_errors += 1;
    end_of_test();
  end
endmodule : mcu_program_flow_control_test
